//--- rtl/ddc_pkg.sv
// Package for the synthesizer core datapath: widths, constants, carrier structs.
// Assumes a single 125 MHz system clock domain.
`default_nettype none
package ddc_pkg;
    // ------------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------------
    localparam int unsigned ACC_W      = 32;
    localparam int unsigned POW_W      = 14;
    localparam int unsigned DAC_W      = 10;
    localparam int unsigned PROF_N     = 8;
    localparam int unsigned PROF_W     = 3;
    localparam int unsigned LUT_AW     = 12;
    // Position of the profile field inside the first control register
    localparam int unsigned PROF_LSB   = 20;
    localparam int unsigned PROF_MSB   = 22;
    // Reset values
    localparam logic [ACC_W-1:0] ACC_RST = 32'h0000_0000;
    localparam logic [DAC_W-1:0] DAC_MID = 10'h200;
    localparam logic [31:0]      CFR_RST = 32'h0000_0000;
    // Pipeline depth from phase accumulator to DAC code
    localparam int unsigned PIPE_LAT   = 3;

    // Auxiliary accumulator uses
    typedef enum logic [1:0] {
        DDC_AUX_OFF   = 2'b00,
        DDC_AUX_SWEEP = 2'b01,
        DDC_AUX_MOD   = 2'b10
    } ddc_aux_mode_t;

    // One profile entry: frequency and phase
    typedef struct packed {
        logic [ACC_W-1:0] frequency_tuning_word;
        logic [POW_W-1:0] phase_offset_word;
    } ddc_prof_t;

    // Host write into the port buffer
    typedef struct packed {
        logic             wr;
        logic [PROF_W-1:0] idx;
        ddc_prof_t        data;
    } ddc_prof_wr_t;

    // Auxiliary accumulator configuration
    typedef struct packed {
        ddc_aux_mode_t    mode;
        logic             dest_phase;
        logic [ACC_W-1:0] step;
        logic [ACC_W-1:0] limit;
        logic [ACC_W-1:0] modulus;
        logic [ACC_W-1:0] extra;
    } ddc_aux_cfg_t;
endpackage
`default_nettype wire

//--- rtl/ddc_core.sv
// DDS core: profiles, phase accumulator, auxiliary accumulator, sine/cosine conversion.
// Assumes the host port protocol is decoded outside; buffered writes arrive here.
`default_nettype none

// Functional notes
// - Output frequency is tuning word over 2^32
// - Linear law except in programmable modulus
// - 14-bit phase offset added before conversion
// - Offset shift is word over 2^14 turns
// - Control bit selects sine or cosine output
// - Auxiliary accumulator sweeps or changes modulus
// - Amplitude samples drive 10-bit DAC code
// - Eight profiles, chosen by bits 22:20 or pins
// - Pins select profile only in serial mode
// - Host loads parameters via serial or parallel port
// - Update strobe moves buffers to active registers
// - Selector value maps directly to profile 0..7
module ddc_core #(
    parameter int unsigned N_PROF = ddc_pkg::PROF_N
) (
    // Clock and reset
    input  wire logic                        clock,
    input  wire logic                        srst,
    // Buffered host port writes
    input  wire ddc_pkg::ddc_prof_wr_t       prof_wr,
    input  wire logic [31:0]                 first_control_register,
    input  wire ddc_pkg::ddc_aux_cfg_t       aux_cfg,
    input  wire logic                        update_strobe,
    // Profile selection pins and port mode
    input  wire logic                        profile_select_pin_bit0,
    input  wire logic                        profile_select_pin_bit1,
    input  wire logic                        profile_select_pin_bit2,
    input  wire logic                        port_select_input,
    input  wire logic                        pin_select_en,
    input  wire logic                        cosine_sel,
    // Outputs
    output logic [ddc_pkg::DAC_W-1:0]        dac_code,
    output logic [ddc_pkg::PROF_W-1:0]       active_profile,
    output logic [ddc_pkg::ACC_W-1:0]        phase_acc
);
    import ddc_pkg::*;

    // ------------------------------------------------------------------
    // Port buffers and active registers
    // ------------------------------------------------------------------
    ddc_prof_t    buf_q   [N_PROF];
    ddc_prof_t    act_q   [N_PROF];
    logic [31:0]  cfr_buf_q, cfr_act_q;
    ddc_aux_cfg_t aux_buf_q, aux_act_q;
    logic         cos_buf_q, cos_act_q;

    // One generate loop per profile entry: buffer on write, copy on update
    for (genvar g = 0; g < N_PROF; g++) begin : g_prof
        ddc_prof_t buf_d, act_d;
        always_comb begin
            buf_d = buf_q[g];
            act_d = act_q[g];
            if (prof_wr.wr && prof_wr.idx == PROF_W'(g)) begin
                buf_d = prof_wr.data;
            end
            if (update_strobe) begin
                act_d = buf_q[g];
            end
        end
        always_ff @(posedge clock) begin
            if (srst) begin
                buf_q[g] <= '0;
                act_q[g] <= '0;
            end else begin
                buf_q[g] <= buf_d;
                act_q[g] <= act_d;
            end
        end
    end

    // Control buffers; the copy only happens on the update strobe
    logic [31:0]  cfr_buf_d, cfr_act_d;
    ddc_aux_cfg_t aux_buf_d, aux_act_d;
    logic         cos_buf_d, cos_act_d;
    always_comb begin
        cfr_buf_d = first_control_register;
        aux_buf_d = aux_cfg;
        cos_buf_d = cosine_sel;
        cfr_act_d = update_strobe ? cfr_buf_q : cfr_act_q;
        aux_act_d = update_strobe ? aux_buf_q : aux_act_q;
        cos_act_d = update_strobe ? cos_buf_q : cos_act_q;
    end
    always_ff @(posedge clock) begin
        if (srst) begin
            cfr_buf_q <= CFR_RST;
            cfr_act_q <= CFR_RST;
            aux_buf_q <= '0;
            aux_act_q <= '0;
            cos_buf_q <= 1'b0;
            cos_act_q <= 1'b0;
        end else begin
            cfr_buf_q <= cfr_buf_d;
            cfr_act_q <= cfr_act_d;
            aux_buf_q <= aux_buf_d;
            aux_act_q <= aux_act_d;
            cos_buf_q <= cos_buf_d;
            cos_act_q <= cos_act_d;
        end
    end

    // ------------------------------------------------------------------
    // Profile selection
    // ------------------------------------------------------------------
    // Pins only count in serial mode; parallel mode shares them with data
    logic [PROF_W-1:0] sel_d, sel_q;
    logic              use_pins;
    always_comb begin
        use_pins = pin_select_en && !port_select_input;
        if (use_pins) begin
            sel_d = {profile_select_pin_bit2, profile_select_pin_bit1, profile_select_pin_bit0};
        end else begin
            sel_d = cfr_act_q[PROF_MSB:PROF_LSB];
        end
    end
    always_ff @(posedge clock) begin
        if (srst) sel_q <= '0;
        else      sel_q <= sel_d;
    end
    assign active_profile = sel_q;
    ddc_prof_t cur;
    assign cur = act_q[sel_q];

    // ------------------------------------------------------------------
    // Auxiliary accumulator
    // ------------------------------------------------------------------
    logic [ACC_W-1:0] aux_d, aux_q;
    logic             carry_d, carry_q;
    logic [ACC_W:0]   aux_sum;
    always_comb begin
        aux_sum = {1'b0, aux_q} + {1'b0, aux_act_q.step};
        aux_d   = aux_q;
        carry_d = 1'b0;
        case (aux_act_q.mode)
            DDC_AUX_MOD: begin
                // Roll over early at the modulus; each rollover adds one LSB to phase
                if (aux_sum >= {1'b0, aux_act_q.modulus}) begin
                    aux_d   = ACC_W'(aux_sum - {1'b0, aux_act_q.modulus});
                    carry_d = 1'b1;
                end else begin
                    aux_d = aux_sum[ACC_W-1:0];
                end
            end
            DDC_AUX_SWEEP: begin
                // Saturate at the limit to avoid an uncontrolled wrapping sweep
                if (aux_sum >= {1'b0, aux_act_q.limit}) aux_d = aux_act_q.limit;
                else                                   aux_d = aux_sum[ACC_W-1:0];
            end
            default: begin
                aux_d = ACC_RST;
            end
        endcase
    end
    always_ff @(posedge clock) begin
        if (srst) begin
            aux_q   <= ACC_RST;
            carry_q <= 1'b0;
        end else begin
            aux_q   <= aux_d;
            carry_q <= carry_d;
        end
    end

    // ------------------------------------------------------------------
    // Phase accumulator
    // ------------------------------------------------------------------
    logic [ACC_W-1:0] ftw_eff, acc_d, acc_q;
    always_comb begin
        ftw_eff = cur.frequency_tuning_word;
        if (aux_act_q.mode == DDC_AUX_SWEEP && !aux_act_q.dest_phase) begin
            ftw_eff = cur.frequency_tuning_word + aux_q;
        end
        // Modulus mode adds only a rollover LSB to the tuning word
        if (aux_act_q.mode == DDC_AUX_MOD) begin
            ftw_eff = cur.frequency_tuning_word + ACC_W'(carry_q);
        end
        acc_d = acc_q + ftw_eff;
    end
    always_ff @(posedge clock) begin
        if (srst) acc_q <= ACC_RST;
        else      acc_q <= acc_d;
    end
    assign phase_acc = acc_q;

    // ------------------------------------------------------------------
    // Phase offset and angle-to-amplitude conversion
    // ------------------------------------------------------------------
    // Offset aligned to the top 14 bits: shift is pow/2^14 of a turn
    logic [POW_W-1:0] pow_eff;
    logic [ACC_W-1:0] ph_d, ph_q;
    always_comb begin
        pow_eff = cur.phase_offset_word;
        if (aux_act_q.mode == DDC_AUX_SWEEP && aux_act_q.dest_phase) begin
            pow_eff = cur.phase_offset_word + aux_q[ACC_W-1 -: POW_W];
        end
        ph_d = acc_q + {pow_eff, {(ACC_W-POW_W){1'b0}}};
        if (cos_act_q) begin
            ph_d = ph_d + {2'b01, {(ACC_W-2){1'b0}}}; // quarter turn
        end
    end
    always_ff @(posedge clock) begin
        if (srst) ph_q <= ACC_RST;
        else      ph_q <= ph_d;
    end

    // Quarter-wave sine table, computed at elaboration; small area cost
    localparam int unsigned QN = 2**(LUT_AW-2);
    logic [DAC_W-2:0] qsin [QN];
    for (genvar k = 0; k < QN; k++) begin : g_lut
        localparam real ANG = 3.14159265358979 * (real'(k) + 0.5) / (2.0 * real'(QN));
        localparam int  VAL = int'($sin(ANG) * 511.0);
        assign qsin[k] = (DAC_W-1)'(VAL);
    end

    logic [LUT_AW-3:0] qidx;
    logic [DAC_W-2:0]  mag;
    logic [DAC_W-1:0]  dac_d;
    always_comb begin
        qidx  = ph_q[ACC_W-2] ? ~ph_q[ACC_W-3 -: LUT_AW-2] : ph_q[ACC_W-3 -: LUT_AW-2];
        mag   = qsin[qidx];
        // Offset binary: midscale plus or minus magnitude
        dac_d = ph_q[ACC_W-1] ? DAC_MID - {1'b0, mag} : DAC_MID + {1'b0, mag};
    end
    always_ff @(posedge clock) begin
        if (srst) dac_code <= DAC_MID;
        else      dac_code <= dac_d;
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_acc_step: assert property (@(posedge clock) disable iff (srst)
        ##1 !$past(srst) |-> acc_q == $past(acc_q) + $past(ftw_eff))
        else $error("phase accumulator did not advance by tuning word");
    a_update_copy: assert property (@(posedge clock) disable iff (srst)
        update_strobe |=> cfr_act_q == $past(cfr_buf_q))
        else $error("update strobe did not load control");
    a_hold_act: assert property (@(posedge clock) disable iff (srst)
        !update_strobe |=> $stable(cfr_act_q))
        else $error("active control changed without update");
    a_par_sel: assert property (@(posedge clock) disable iff (srst)
        port_select_input |=> sel_q == $past(cfr_act_q[PROF_MSB:PROF_LSB]))
        else $error("pins selected profile in parallel mode");
    a_pin_sel: assert property (@(posedge clock) disable iff (srst)
        (pin_select_en && !port_select_input) |=>
        sel_q == $past({profile_select_pin_bit2, profile_select_pin_bit1, profile_select_pin_bit0}))
        else $error("pin profile select not honoured");
    a_phase_off: assert property (@(posedge clock) disable iff (srst)
        (aux_act_q.mode != DDC_AUX_SWEEP && !cos_act_q) |=>
        ph_q == $past(acc_q) + {$past(cur.phase_offset_word), 18'h00000})
        else $error("phase offset not applied");
    a_cos_shift: assert property (@(posedge clock) disable iff (srst)
        (aux_act_q.mode != DDC_AUX_SWEEP && cos_act_q) |=>
        ph_q == $past(acc_q) + {$past(cur.phase_offset_word), 18'h00000} + 32'h4000_0000)
        else $error("cosine quarter turn missing");
    a_mod_carry: assert property (@(posedge clock) disable iff (srst)
        carry_q |-> aux_act_q.mode == DDC_AUX_MOD || $past(aux_act_q.mode) == DDC_AUX_MOD)
        else $error("modulus carry outside modulus mode");
    a_dac_zero: assert property (@(posedge clock) disable iff (srst)
        ##1 ($past(ph_q[ACC_W-1:ACC_W-2]) == 2'b00) |-> dac_code >= DAC_MID)
        else $error("first quadrant sample below midscale");

    c_update: cover property (@(posedge clock) disable iff (srst) update_strobe ##1 sel_q != 3'h0);
    c_mod_roll: cover property (@(posedge clock) disable iff (srst) carry_q);
    c_cosine: cover property (@(posedge clock) disable iff (srst) cos_act_q && acc_q != ACC_RST);
    c_pin_sel: cover property (@(posedge clock) disable iff (srst) use_pins && sel_d == 3'h7);
endmodule
`default_nettype wire

//--- test/ddc_host_model.sv
// Host model: loads profile buffers, picks the port mode, issues update strobes.
// Assumes the bench calls its tasks and that it shares the core clock.
`default_nettype none
module ddc_host_model
    import ddc_pkg::*;
(
    // Clock
    input  wire logic                 clock,
    // Port towards the core
    output var ddc_pkg::ddc_prof_wr_t prof_wr,
    output logic                      update_strobe,
    output logic                      port_select_input
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle after power-up, serial mode
    initial begin
        prof_wr = '0;
        update_strobe = 1'b0;
        port_select_input = 1'b0;
    end

    // One profile write; the word is kept in the lower half of the range
    task automatic write_prof(input logic [2:0] idx, input logic [30:0] frequency_tuning_word, input logic [13:0] pw);
        @(negedge clock);
        prof_wr <= '{wr: 1'b1, idx: idx, data: '{frequency_tuning_word: {1'b0, frequency_tuning_word}, phase_offset_word: pw}};
        @(negedge clock);
        prof_wr.wr <= 1'b0;
        prof_wr.data <= ~prof_wr.data; // Stale data must not be relied on
    endtask

    // Low for serial, high for parallel programming
    task automatic set_port(input logic par);
        @(negedge clock);
        port_select_input <= par;
    endtask

    // One-cycle update strobe
    task automatic update();
        @(negedge clock);
        update_strobe <= 1'b1;
        @(negedge clock);
        update_strobe <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- test/tb_dds_core_profile_datapath.sv
// Self-checking bench for the synthesizer core: profiles, selection, datapath.
// Assumes ddc_pkg, ddc_core and the host model are compiled first.
`default_nettype none
module tb_dds_core_profile_datapath;
    import ddc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] cfr_sel;
        logic [2:0] pins;
        logic       par;
        logic       pin_en;
        logic [2:0] exp;
    } ddc_row_t;

    logic          clock;
    logic          srst;
    logic [31:0]   cfr;
    ddc_aux_cfg_t  aux;
    logic [2:0]    pins;
    logic          pin_en;
    logic          cos_sel;
    ddc_prof_wr_t  prof_wr;
    logic          update_strobe;
    logic          port_sel;
    logic [9:0]    dac_code;
    logic [2:0]    active_profile;
    logic [31:0]   phase_acc;
    int            failures;
    int            num_checks;
    logic [30:0]   frequency_tuning_word [8];

    ddc_host_model host (.clock(clock), .prof_wr(prof_wr), .update_strobe(update_strobe),
                         .port_select_input(port_sel));
    ddc_core uut (.clock(clock), .srst(srst), .prof_wr(prof_wr), .first_control_register(cfr),
                  .aux_cfg(aux), .update_strobe(update_strobe), .profile_select_pin_bit0(pins[0]),
                  .profile_select_pin_bit1(pins[1]), .profile_select_pin_bit2(pins[2]),
                  .port_select_input(port_sel), .pin_select_en(pin_en), .cosine_sel(cos_sel),
                  .dac_code(dac_code), .active_profile(active_profile), .phase_acc(phase_acc));

    // Selection table: the last row leaves profile 0 active
    localparam ddc_row_t ROWS [16] = '{
        {3'h0, 3'h7, 1'b0, 1'b0, 3'h0}, {3'h1, 3'h6, 1'b1, 1'b1, 3'h1},
        {3'h2, 3'h5, 1'b0, 1'b0, 3'h2}, {3'h3, 3'h4, 1'b1, 1'b0, 3'h3},
        {3'h4, 3'h3, 1'b1, 1'b1, 3'h4}, {3'h5, 3'h2, 1'b0, 1'b0, 3'h5},
        {3'h6, 3'h1, 1'b1, 1'b1, 3'h6}, {3'h7, 3'h0, 1'b0, 1'b0, 3'h7},
        {3'h7, 3'h3, 1'b0, 1'b1, 3'h3}, {3'h6, 3'h2, 1'b0, 1'b1, 3'h2},
        {3'h5, 3'h5, 1'b0, 1'b1, 3'h5}, {3'h3, 3'h1, 1'b0, 1'b1, 3'h1},
        {3'h0, 3'h4, 1'b0, 1'b1, 3'h4}, {3'h2, 3'h7, 1'b0, 1'b1, 3'h7},
        {3'h4, 3'h6, 1'b0, 1'b1, 3'h6}, {3'h1, 3'h0, 1'b0, 1'b1, 3'h0}};
    localparam logic [13:0] PWS [4] = '{14'h0000, 14'h0400, 14'h0C00, 14'h1555};

    // 8 ns clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // ----------------------------------------------------------------
    // Compare and helper tasks
    // ----------------------------------------------------------------
    task automatic tally(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        tally(got, exp);
    endtask
    task automatic chk_code(input logic [9:0] got, input logic [9:0] exp);
        tally({22'h0, got}, {22'h0, exp});
    endtask
    task automatic chk_prof(input logic [2:0] got, input logic [2:0] exp);
        tally({29'h0, got}, {29'h0, exp});
    endtask

    // Phase advance over n clocks, sampled where settled
    task automatic advance(input int n, output logic [31:0] d);
        logic [31:0] a;
        @(negedge clock);
        a = phase_acc;
        repeat (n) @(negedge clock);
        d = phase_acc - a;
    endtask

    // Held reset; outputs at their reset values while it lasts
    task automatic do_reset();
        srst = 1'b1;
        repeat (5) @(negedge clock);
        chk_word(phase_acc, 32'h0);
        chk_code(dac_code, 10'h200);
        chk_prof(active_profile, 3'h0);
        srst = 1'b0;
    endtask

    // Frozen phase (zero word after reset), so the code depends on offset and cosine select only
    task automatic dac_at(input logic [13:0] pw, input logic c, output logic [9:0] d);
        cos_sel = c;
        host.write_prof(3'h0, 31'h0, pw);
        host.update();
        repeat (6) @(negedge clock);
        d = dac_code;
    endtask

    task automatic print_verdict();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Watchdog: the sequence needs well under 3000 clocks
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        print_verdict();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [9:0]  s0;
        logic [9:0]  s1;
        srst = 1'b1;
        cfr = 32'h0;
        aux = '0;
        pins = 3'h0;
        pin_en = 1'b0;
        cos_sel = 1'b0;
        failures = 0;
        num_checks = 0;
        do_reset();
        // Back-to-back profile loads; profile 7 at the top legal word to force wraps
        for (int k = 0; k < 8; k++) begin
            frequency_tuning_word[k] = (k == 7) ? 31'h7FFF_FFFF : 31'h1000_0000 + 31'(k) * 31'h0111_1111;
            host.write_prof(3'(k), frequency_tuning_word[k], 14'h0);
        end
        foreach (ROWS[i]) begin
            @(negedge clock);
            cfr[22:20] = ROWS[i].cfr_sel;
            pins = ROWS[i].pins;
            pin_en = ROWS[i].pin_en;
            host.set_port(ROWS[i].par);
            host.update();
            repeat (3) @(negedge clock);
            chk_prof(active_profile, ROWS[i].exp);
            advance(1, d);
            chk_word(d, {1'b0, frequency_tuning_word[ROWS[i].exp]});
        end
        // A buffered write stays hidden until the update strobe
        host.write_prof(3'h0, 31'h0000_1234, 14'h0);
        advance(1, d);
        chk_word(d, {1'b0, frequency_tuning_word[0]});
        host.update();
        advance(1, d);
        chk_word(d, 32'h0000_1234);
        // Frequency sweep saturates at its limit
        aux = '{mode: DDC_AUX_SWEEP, dest_phase: 1'b0, step: 32'h10, limit: 32'h100, modulus: '0, extra: '0};
        host.update();
        repeat (30) @(negedge clock);
        advance(1, d);
        chk_word(d, 32'h0000_1334);
        // Mid-run reset, then modulus 4: one extra step every four clocks
        aux = '0;
        do_reset();
        aux = '{mode: DDC_AUX_MOD, dest_phase: 1'b0, step: 32'h1, limit: '0, modulus: 32'h4, extra: '0};
        host.write_prof(3'h0, 31'h0000_1234, 14'h0);
        host.update();
        repeat (10) @(negedge clock);
        advance(40, d);
        chk_word(d, 32'h0002_D82A);
        // Offset, sine/cosine and code symmetry on a frozen phase
        aux = '0;
        do_reset();
        foreach (PWS[i]) begin
            dac_at(PWS[i], 1'b0, s0);
            dac_at(PWS[i] + 14'h2000, 1'b0, s1);
            chk_word({22'h0, s0} + {22'h0, s1}, 32'h400);
            dac_at(PWS[i], 1'b1, s0);
            dac_at(PWS[i] + 14'h1000, 1'b0, s1);
            chk_code(s0, s1);
        end
        dac_at(14'h1000, 1'b0, s0);
        chk_word({31'h0, s0 > 10'h3F0}, 32'h1);
        print_verdict();
    end
endmodule
`default_nettype wire
